// ### rtl/cfip_pkg.sv
// Constants and carrier types shared by the calibration image parser.
package cfip_pkg;

  // Image signatures and checksum parameters.
  localparam logic [31:0] CFIP_CFG_SIG    = 32'hddccbbaa;
  localparam logic [31:0] CFIP_TBL_SIG    = 32'h66778899;
  localparam logic [15:0] CFIP_ROW_SIG    = 16'h4455;
  localparam logic [15:0] CFIP_XROW_SIG   = 16'h2233;
  localparam logic [15:0] CFIP_CRC_POLY   = 16'ha001;
  localparam logic [15:0] CFIP_CRC_INIT   = 16'hffff;

  // Configuration block offsets (last byte of each multi-byte field).
  localparam logic [7:0]  CFIP_OFF_SIG_END  = 8'h03;
  localparam logic [7:0]  CFIP_OFF_PRODUCT  = 8'h05;
  localparam logic [7:0]  CFIP_OFF_VERSION  = 8'h07;
  localparam logic [7:0]  CFIP_OFF_SERIAL   = 8'h09;
  localparam logic [7:0]  CFIP_OFF_BATCH    = 8'h0a;
  localparam logic [7:0]  CFIP_OFF_YEAR     = 8'h0b;
  localparam logic [7:0]  CFIP_OFF_MONTH    = 8'h0c;
  localparam logic [7:0]  CFIP_OFF_DAY      = 8'h0d;
  localparam logic [7:0]  CFIP_OFF_PAD0_LO  = 8'h0e;
  localparam logic [7:0]  CFIP_OFF_PAD0_HI  = 8'h0f;
  localparam logic [7:0]  CFIP_OFF_REF_END  = 8'h13;
  localparam logic [7:0]  CFIP_OFF_LEN_END  = 8'h17;
  localparam logic [7:0]  CFIP_OFF_PAD1_LO  = 8'h1c;
  localparam logic [7:0]  CFIP_OFF_CRC_LAST = 8'hfd;
  localparam logic [7:0]  CFIP_OFF_CKS_HI   = 8'hff;
  localparam logic [7:0]  CFIP_PAGE_LAST    = 8'hff;
  localparam logic [31:0] CFIP_DATA_BASE    = 32'h00000100;
  localparam logic [31:0] CFIP_DATA_END_ADJ = 32'h000000ff;

  // Field limits and conversions.
  localparam logic [15:0] CFIP_SERIAL_MAX  = 16'h03e7;
  localparam logic [7:0]  CFIP_BATCH_MAX   = 8'h09;
  localparam logic [7:0]  CFIP_DAY_MIN     = 8'h01;
  localparam logic [7:0]  CFIP_DAY_MAX     = 8'h1f;
  localparam logic [15:0] CFIP_YEAR_BASE   = 16'h07b2;
  localparam logic [31:0] CFIP_HZ_PER_MHZ  = 32'h000f4240;

  // Table header offsets.
  localparam logic [4:0]  CFIP_T_SIG_END   = 5'h03;
  localparam logic [4:0]  CFIP_T_KIND      = 5'h04;
  localparam logic [4:0]  CFIP_T_XFMT      = 5'h05;
  localparam logic [4:0]  CFIP_T_YFMT      = 5'h06;
  localparam logic [4:0]  CFIP_T_ZFMT      = 5'h07;
  localparam logic [4:0]  CFIP_T_ZTOT_END  = 5'h0b;
  localparam logic [4:0]  CFIP_T_XYTOT_END = 5'h0f;
  localparam logic [4:0]  CFIP_T_XROW_END  = 5'h11;
  localparam logic [4:0]  CFIP_T_SCALE     = 5'h12;
  localparam logic [4:0]  CFIP_T_HDR_END   = 5'h13;
  localparam logic [7:0]  CFIP_KIND_LEVEL  = 8'h08;
  localparam logic [15:0] CFIP_Y_UNUSABLE  = 16'hffff;
  localparam logic [15:0] CFIP_Y_VALID_MAX = 16'h7fff;

  // Register byte offsets, control start bit and response codes.
  localparam logic [7:0]  CFIP_REG_CTRL    = 8'h00;
  localparam logic [7:0]  CFIP_REG_STATUS  = 8'h04;
  localparam logic [7:0]  CFIP_REG_IDENT   = 8'h08;
  localparam logic [7:0]  CFIP_REG_SERIAL  = 8'h0c;
  localparam logic [7:0]  CFIP_REG_DATE    = 8'h10;
  localparam logic [7:0]  CFIP_REG_REF_HZ  = 8'h14;
  localparam logic [7:0]  CFIP_REG_REF_MHZ = 8'h18;
  localparam logic [7:0]  CFIP_REG_DATALEN = 8'h1c;
  localparam logic [7:0]  CFIP_REG_TABLE   = 8'h20;
  localparam logic [7:0]  CFIP_REG_SCALE   = 8'h24;
  localparam logic [7:0]  CFIP_REG_ZTOT    = 8'h28;
  localparam logic [7:0]  CFIP_REG_XYTOT   = 8'h2c;
  localparam logic [7:0]  CFIP_REG_CRC     = 8'h30;
  localparam logic [7:0]  CFIP_REG_LAST    = 8'h30;
  localparam int          CFIP_CTRL_START  = 0;
  localparam logic [1:0]  CFIP_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  CFIP_RESP_DECERR = 2'b11;

  typedef enum logic [3:0] {
    CFIP_ERR_NONE     = 4'b0000,
    CFIP_ERR_CFG_SIG  = 4'b0001,
    CFIP_ERR_RANGE    = 4'b0010,
    CFIP_ERR_CFG_PAD  = 4'b0011,
    CFIP_ERR_CFG_CRC  = 4'b0100,
    CFIP_ERR_TBL_SIG  = 4'b0101,
    CFIP_ERR_XROW_SIG = 4'b0110,
    CFIP_ERR_ROW_SIG  = 4'b0111,
    CFIP_ERR_DATA_CRC = 4'b1000
  } cfip_err_t;

  typedef enum logic [1:0] {
    CFIP_CLS_VALID    = 2'b00,
    CFIP_CLS_COARSE   = 2'b01,
    CFIP_CLS_UNUSABLE = 2'b10
  } cfip_cls_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cfip_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cfip_axi_rsp_t;

  typedef struct packed {
    logic        rd;
    logic [23:0] addr;
  } cfip_flash_req_t;

  typedef struct packed {
    logic        rvalid;
    logic [7:0]  rdata;
  } cfip_flash_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  kind;
    logic        is_y;
    logic [15:0] row;
    logic [15:0] col;
    logic [15:0] z;
    logic [15:0] value;
    cfip_cls_t   cls;
  } cfip_point_t;

endpackage

// ### rtl/cfip_parser.sv
// Calibration flash image parser with an AXI4-Lite register slave.
`timescale 1ns/10ps
module cfip_parser
  import cfip_pkg::*;
(
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     srst,
  // Register bus.
  input  wire cfip_pkg::cfip_axi_req_t  axi_req,
  output      cfip_pkg::cfip_axi_rsp_t  axi_rsp,
  // Flash byte reader.
  output      cfip_pkg::cfip_flash_req_t flash_req,
  input  wire cfip_pkg::cfip_flash_rsp_t flash_rsp,
  // Decoded grid points.
  output      cfip_pkg::cfip_point_t    point
);
  import cfip_pkg::*;

  typedef enum logic [2:0] {
    RUN_IDLE = 3'b000,
    RUN_REQ  = 3'b001,
    RUN_WAIT = 3'b010,
    RUN_DONE = 3'b011,
    RUN_FAIL = 3'b100
  } cfip_run_t;

  typedef enum logic [1:0] {
    PH_CFG  = 2'b00,
    PH_DATA = 2'b01,
    PH_CKS  = 2'b10
  } cfip_phase_t;

  typedef enum logic [2:0] {
    TP_HDR  = 3'b000,
    TP_X    = 3'b001,
    TP_RSIG = 3'b010,
    TP_RZ   = 3'b011,
    TP_RY   = 3'b100,
    TP_PAD  = 3'b101
  } cfip_tp_t;

  typedef struct packed {
    cfip_axi_rsp_t   rsp;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [31:0]     wdata;
    logic            wstrb0;
    cfip_flash_req_t flash;
    cfip_point_t     point;
    cfip_run_t       run;
    cfip_phase_t     phase;
    cfip_tp_t        tp;
    cfip_err_t       err;
    logic            ok;
    logic            level_found;
    logic [31:0]     addr;
    logic [31:0]     sh;
    logic [15:0]     crc;
    logic [15:0]     product;
    logic [15:0]     version;
    logic [15:0]     serial;
    logic [7:0]      batch;
    logic [15:0]     year;
    logic [7:0]      month;
    logic [7:0]      day;
    logic [31:0]     ref_hz;
    logic [31:0]     ref_mhz;
    logic [31:0]     data_len;
    logic [7:0]      kind;
    logic [7:0]      xfmt;
    logic [7:0]      yfmt;
    logic [7:0]      zfmt;
    logic [7:0]      xscale;
    logic [31:0]     ztot;
    logic [31:0]     xytot;
    logic [31:0]     toff;
    logic [31:0]     col;
    logic [31:0]     row;
    logic [15:0]     zval;
  } cfip_state_t;

  cfip_state_t s;
  cfip_state_t next_s;

  // Bitwise reflected CRC step over one byte.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CFIP_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= CFIP_REG_LAST);
  endfunction

  // A table that ends on the last byte of a page lets the next header start at once.
  function automatic cfip_tp_t after_table(input logic [7:0] a);
    return (a == CFIP_PAGE_LAST) ? TP_HDR : TP_PAD;
  endfunction

  assign axi_rsp   = s.rsp;
  assign flash_req = s.flash;
  assign point     = s.point;

  always_comb begin
    logic [7:0]  b;
    logic [7:0]  a8;
    logic [31:0] sh;
    logic        fail;
    logic        fin;
    logic        start;
    cfip_err_t   ecode;
    next_s = s;
    b      = flash_rsp.rdata;
    a8     = s.addr[7:0];
    sh     = {b, s.sh[31:8]};
    fail   = 1'b0;
    fin    = 1'b0;
    start  = 1'b0;
    ecode  = CFIP_ERR_NONE;
    next_s.flash.rd    = 1'b0;
    next_s.point.valid = 1'b0;

    // Write channel: address and data are taken independently, answered once both are in.
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = axi_req.wdata;
      next_s.wstrb0 = axi_req.wstrb[0];
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got     = 1'b0;
      next_s.w_got      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = reg_known(s.awaddr) ? CFIP_RESP_OKAY : CFIP_RESP_DECERR;
      start = (s.awaddr == CFIP_REG_CTRL) && s.wstrb0 && s.wdata[CFIP_CTRL_START] &&
              (s.run != RUN_REQ) && (s.run != RUN_WAIT);
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.w_got && !next_s.rsp.bvalid;

    // Read channel.
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp  = reg_known(axi_req.araddr) ? CFIP_RESP_OKAY : CFIP_RESP_DECERR;
      case (axi_req.araddr)
        CFIP_REG_STATUS: begin
          next_s.rsp.rdata = {24'h000000, s.err, s.level_found, s.ok,
                              (s.run == RUN_DONE) || (s.run == RUN_FAIL),
                              (s.run == RUN_REQ) || (s.run == RUN_WAIT)};
        end
        CFIP_REG_IDENT:   next_s.rsp.rdata = {s.version, s.product};
        CFIP_REG_SERIAL:  next_s.rsp.rdata = {8'h00, s.batch, s.serial};
        CFIP_REG_DATE:    next_s.rsp.rdata = {s.day, s.month, s.year};
        CFIP_REG_REF_HZ:  next_s.rsp.rdata = s.ref_hz;
        CFIP_REG_REF_MHZ: next_s.rsp.rdata = s.ref_mhz;
        CFIP_REG_DATALEN: next_s.rsp.rdata = s.data_len;
        CFIP_REG_TABLE:   next_s.rsp.rdata = {s.kind, s.xfmt, s.yfmt, s.zfmt};
        CFIP_REG_SCALE:   next_s.rsp.rdata = {24'h000000, s.xscale};
        CFIP_REG_ZTOT:    next_s.rsp.rdata = s.ztot;
        CFIP_REG_XYTOT:   next_s.rsp.rdata = s.xytot;
        CFIP_REG_CRC:     next_s.rsp.rdata = {16'h0000, s.crc};
        default:          next_s.rsp.rdata = 32'h00000000;
      endcase
    end else if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // Flash walk: one byte outstanding, addresses strictly ascending.
    case (s.run)
      RUN_REQ: begin
        next_s.flash.rd   = 1'b1;
        next_s.flash.addr = s.addr[23:0];
        next_s.run        = RUN_WAIT;
      end
      RUN_WAIT: begin
        if (flash_rsp.rvalid) begin
          next_s.sh   = sh;
          next_s.addr = s.addr + 32'h00000001;
          case (s.phase)
            PH_CFG: begin
              if (a8 <= CFIP_OFF_CRC_LAST) begin
                next_s.crc = crc_byte(s.crc, b);
              end
              case (a8)
                CFIP_OFF_SIG_END: begin
                  if (sh != CFIP_CFG_SIG) begin
                    fail  = 1'b1;
                    ecode = CFIP_ERR_CFG_SIG;
                  end
                end
                CFIP_OFF_PRODUCT: next_s.product = sh[31:16];
                CFIP_OFF_VERSION: next_s.version = sh[31:16];
                CFIP_OFF_SERIAL: begin
                  next_s.serial = sh[31:16];
                  if (sh[31:16] > CFIP_SERIAL_MAX) begin
                    fail  = 1'b1;
                    ecode = CFIP_ERR_RANGE;
                  end
                end
                CFIP_OFF_BATCH: begin
                  next_s.batch = b;
                  if (b > CFIP_BATCH_MAX) begin
                    fail  = 1'b1;
                    ecode = CFIP_ERR_RANGE;
                  end
                end
                CFIP_OFF_YEAR:  next_s.year = {8'h00, b} + CFIP_YEAR_BASE;
                CFIP_OFF_MONTH: next_s.month = b;
                CFIP_OFF_DAY: begin
                  next_s.day = b;
                  if ((b < CFIP_DAY_MIN) || (b > CFIP_DAY_MAX)) begin
                    fail  = 1'b1;
                    ecode = CFIP_ERR_RANGE;
                  end
                end
                CFIP_OFF_REF_END: next_s.ref_hz = sh;
                CFIP_OFF_LEN_END: next_s.data_len = sh;
                CFIP_OFF_CKS_HI: begin
                  if (sh[31:16] != s.crc) begin
                    fail  = 1'b1;
                    ecode = CFIP_ERR_CFG_CRC;
                  end else begin
                    // A constant divisor keeps the conversion combinational; it runs once.
                    next_s.ref_mhz = s.ref_hz / CFIP_HZ_PER_MHZ;
                    next_s.crc     = CFIP_CRC_INIT;
                    next_s.tp      = TP_HDR;
                    next_s.toff    = 32'h00000000;
                    next_s.phase   = (s.data_len == 32'h00000000) ? PH_CKS : PH_DATA;
                  end
                end
                default: begin
                  if (((a8 >= CFIP_OFF_PAD0_LO) && (a8 <= CFIP_OFF_PAD0_HI)) ||
                      ((a8 >= CFIP_OFF_PAD1_LO) && (a8 <= CFIP_OFF_CRC_LAST))) begin
                    if (b != 8'h00) begin
                      fail  = 1'b1;
                      ecode = CFIP_ERR_CFG_PAD;
                    end
                  end
                end
              endcase
            end
            PH_DATA: begin
              next_s.crc  = crc_byte(s.crc, b);
              next_s.toff = s.toff + 32'h00000001;
              if (s.addr == s.data_len + CFIP_DATA_END_ADJ) begin
                next_s.phase = PH_CKS;
              end
              case (s.tp)
                TP_HDR: begin
                  case (s.toff[4:0])
                    CFIP_T_SIG_END: begin
                      if (sh != CFIP_TBL_SIG) begin
                        fail  = 1'b1;
                        ecode = CFIP_ERR_TBL_SIG;
                      end
                    end
                    CFIP_T_KIND:      next_s.kind = b;
                    CFIP_T_XFMT:      next_s.xfmt = b;
                    CFIP_T_YFMT:      next_s.yfmt = b;
                    CFIP_T_ZFMT:      next_s.zfmt = b;
                    CFIP_T_ZTOT_END:  next_s.ztot = sh;
                    CFIP_T_XYTOT_END: next_s.xytot = sh;
                    CFIP_T_XROW_END: begin
                      if (sh[31:16] != CFIP_XROW_SIG) begin
                        fail  = 1'b1;
                        ecode = CFIP_ERR_XROW_SIG;
                      end
                    end
                    CFIP_T_SCALE: next_s.xscale = b;
                    CFIP_T_HDR_END: begin
                      next_s.tp   = TP_X;
                      next_s.toff = 32'h00000000;
                      next_s.col  = 32'h00000000;
                      if (s.kind == CFIP_KIND_LEVEL) begin
                        next_s.level_found = 1'b1;
                      end
                    end
                    default: ;
                  endcase
                end
                TP_X: begin
                  if (s.toff[0]) begin
                    next_s.point.valid = 1'b1;
                    next_s.point.kind  = s.kind;
                    next_s.point.is_y  = 1'b0;
                    next_s.point.row   = 16'h0000;
                    next_s.point.col   = s.col[15:0];
                    next_s.point.z     = 16'h0000;
                    next_s.point.value = sh[31:16];
                    next_s.point.cls   = CFIP_CLS_VALID;
                    next_s.col         = s.col + 32'h00000001;
                    if (next_s.col == s.xytot) begin
                      next_s.toff = 32'h00000000;
                      next_s.row  = 32'h00000000;
                      next_s.tp   = (s.ztot == 32'h00000000) ? after_table(a8) : TP_RSIG;
                    end
                  end
                end
                TP_RSIG: begin
                  if (s.toff[0]) begin
                    if (sh[31:16] != CFIP_ROW_SIG) begin
                      fail  = 1'b1;
                      ecode = CFIP_ERR_ROW_SIG;
                    end
                    next_s.tp   = TP_RZ;
                    next_s.toff = 32'h00000000;
                  end
                end
                TP_RZ: begin
                  if (s.toff[0]) begin
                    next_s.zval = sh[31:16];
                    next_s.tp   = TP_RY;
                    next_s.toff = 32'h00000000;
                    next_s.col  = 32'h00000000;
                  end
                end
                TP_RY: begin
                  if (s.toff[0]) begin
                    next_s.point.valid = 1'b1;
                    next_s.point.kind  = s.kind;
                    next_s.point.is_y  = 1'b1;
                    next_s.point.row   = s.row[15:0];
                    next_s.point.col   = s.col[15:0];
                    next_s.point.z     = s.zval;
                    next_s.point.value = sh[31:16];
                    if (sh[31:16] == CFIP_Y_UNUSABLE) begin
                      next_s.point.cls = CFIP_CLS_UNUSABLE;
                    end else if (sh[31:16] > CFIP_Y_VALID_MAX) begin
                      next_s.point.cls = CFIP_CLS_COARSE;
                    end else begin
                      next_s.point.cls = CFIP_CLS_VALID;
                    end
                    next_s.col = s.col + 32'h00000001;
                    if (next_s.col == s.xytot) begin
                      next_s.row  = s.row + 32'h00000001;
                      next_s.toff = 32'h00000000;
                      next_s.tp   = (next_s.row == s.ztot) ? after_table(a8) : TP_RSIG;
                    end
                  end
                end
                TP_PAD: begin
                  if (a8 == CFIP_PAGE_LAST) begin
                    next_s.tp   = TP_HDR;
                    next_s.toff = 32'h00000000;
                  end
                end
                default: next_s.tp = TP_HDR;
              endcase
            end
            PH_CKS: begin
              if (s.addr == s.data_len + CFIP_DATA_BASE + 32'h00000001) begin
                if (sh[31:16] != s.crc) begin
                  fail  = 1'b1;
                  ecode = CFIP_ERR_DATA_CRC;
                end else begin
                  fin = 1'b1;
                end
              end
            end
            default: next_s.phase = PH_CFG;
          endcase
          next_s.run = fin ? RUN_DONE : RUN_REQ;
          next_s.ok  = fin;
        end
      end
      default: ;
    endcase

    // Any mismatch stops the walk and leaves the image marked invalid.
    if (fail) begin
      next_s.run = RUN_FAIL;
      next_s.ok  = 1'b0;
      next_s.err = ecode;
    end

    if (start) begin
      next_s.run         = RUN_REQ;
      next_s.phase       = PH_CFG;
      next_s.addr        = 32'h00000000;
      next_s.crc         = CFIP_CRC_INIT;
      next_s.err         = CFIP_ERR_NONE;
      next_s.ok          = 1'b0;
      next_s.level_found = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// ### bench/cfip_parser_props.sv
// Port assertions for the calibration image parser.
`timescale 1ns/10ps
module cfip_props
  import cfip_pkg::*;
(
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      srst,
  // Watched ports.
  input wire cfip_pkg::cfip_axi_req_t   axi_req,
  input wire cfip_pkg::cfip_axi_rsp_t   axi_rsp,
  input wire cfip_pkg::cfip_flash_req_t flash_req,
  input wire cfip_pkg::cfip_flash_rsp_t flash_rsp,
  input wire cfip_pkg::cfip_point_t     point
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  rd_single_a: assert property (flash_req.rd |=> !flash_req.rd)
    else $error("flash read held");
  addr_step_a: assert property (flash_req.rd && $past(flash_rsp.rvalid, 2)
    |-> flash_req.addr == $past(flash_req.addr) + 24'h1) else $error("address skipped");
  y_class_a: assert property (point.valid && point.is_y |-> point.cls ==
    (point.value == 16'hffff ? CFIP_CLS_UNUSABLE :
     point.value > 16'h7fff ? CFIP_CLS_COARSE : CFIP_CLS_VALID)) else $error("bad class");
  x_point_a: assert property (point.valid && !point.is_y |-> point.z == 16'h0
    && point.row == 16'h0 && point.cls == CFIP_CLS_VALID) else $error("bad X point");
  point_pulse_a: assert property (point.valid |=> !point.valid)
    else $error("point held");
  read_ans_a: assert property (rd_taken |=> axi_rsp.rvalid) else $error("no read data");
  unmapped_a: assert property (rd_taken ##0 axi_req.araddr > 8'h30 |=>
    axi_rsp.rresp == CFIP_RESP_DECERR && axi_rsp.rdata == 32'h0) else $error("bad decerr");
  write_ans_a: assert property (wr_taken |-> ##[1:2] axi_rsp.bvalid) else $error("no bresp");
  busy_ready_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("ready during response");
endmodule
bind cfip_parser cfip_props u_cfip_props (.clk(clk), .srst(srst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .flash_req(flash_req), .flash_rsp(flash_rsp), .point(point));

// ### bench/cfip_flash_model.sv
// Byte-wide flash model that answers each read after a varying delay.
`timescale 1ns/10ps
module cfip_flash_model
  import cfip_pkg::*;
(
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      srst,
  // Reader side.
  input wire cfip_pkg::cfip_flash_req_t flash_req,
  output     cfip_pkg::cfip_flash_rsp_t flash_rsp
);
  logic [7:0] mem [0:1023];
  logic [1:0] wait_cnt;
  logic       busy;
  always_ff @(posedge clk) begin
    flash_rsp.rvalid <= 1'b0;
    // Idle data toggles so a stale byte is never mistaken for a reply.
    flash_rsp.rdata <= ~flash_rsp.rdata;
    if (srst) begin
      busy <= 1'b0;
      flash_rsp.rdata <= 8'h5a;
    end else if (flash_req.rd) begin
      busy <= 1'b1;
      wait_cnt <= flash_req.addr[1:0];
    end else if (busy && wait_cnt == 2'h0) begin
      busy <= 1'b0;
      flash_rsp.rvalid <= 1'b1;
      flash_rsp.rdata <= mem[flash_req.addr[9:0]];
    end else if (busy) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule

// ### bench/cfip_parser_test.sv
// Self-checking bench for the calibration image parser.
`timescale 1ns/10ps
module cfip_parser_test;
  import cfip_pkg::*;
  logic clk, srst, chk_pts;
  cfip_axi_req_t axi_req;
  cfip_axi_rsp_t axi_rsp;
  cfip_flash_req_t flash_req;
  cfip_flash_rsp_t flash_rsp;
  cfip_point_t point;
  cfip_point_t exp_q[$];
  int n_fail, cmp_count, seed, i, k;
  int ca[9] = '{1000, 2, 13, 15, 254, 258, 272, 280, 512};
  logic [1:0] r;
  logic [31:0] d;
  logic [31:0] ex[11];
  logic [7:0] ra[11];
  logic [15:0] prod, ver, ser, xv[2], zv[2], yv[4];
  logic [7:0] bat, yr;
  cfip_parser u_cfip_parser (.clk(clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .flash_req(flash_req), .flash_rsp(flash_rsp), .point(point));
  cfip_flash_model u_cfip_flash_model (.clk(clk), .srst(srst), .flash_req(flash_req),
    .flash_rsp(flash_rsp));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    final_report();
  endtask
  task automatic chk(input string nm, input logic [91:0] e, input logic [91:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic put(input int a, input logic [31:0] x, input int n);
    for (int j = 0; j < n; j++) u_cfip_flash_model.mem[a + j] = x[8*j +: 8];
  endtask
  function automatic logic [15:0] crc(input int lo, input int hi);
    logic [15:0] c;
    c = 16'hffff;
    for (int a = lo; a <= hi; a++) begin
      c ^= {8'h00, u_cfip_flash_model.mem[a]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic fix();
    put(254, 32'(crc(0, 253)), 2);
    put(512, 32'(crc(256, 511)), 2);
  endtask
  function automatic cfip_cls_t cls(input logic [15:0] y);
    return y == 16'hffff ? CFIP_CLS_UNUSABLE : y > 16'h7fff ? CFIP_CLS_COARSE : CFIP_CLS_VALID;
  endfunction
  task automatic build(input int a);
    int p;
    p = 276;
    exp_q = {};
    for (i = 0; i < 1024; i++) u_cfip_flash_model.mem[i] = 8'h00;
    put(0, 32'hddccbbaa, 4);
    put(4, {ver, prod}, 4);
    put(8, {8'h0, bat, ser}, 3);
    put(11, {8'h0, 8'h1f, 8'h0c, yr}, 3);
    put(16, 32'd147000000, 4);
    put(20, 32'h100, 4);
    put(256, 32'h66778899, 4);
    put(260, 32'h01010108, 4);
    put(264, 32'h2, 4);
    put(268, 32'h2, 4);
    put(272, 32'h00062233, 4);
    for (i = 0; i < 6; i++) begin
      if (i > 1 && i % 2 == 0) begin
        put(p, {zv[i/2-1], 16'h4455}, 4);
        p += 4;
      end
      put(p, (i < 2) ? 32'(xv[i]) : 32'(yv[i-2]), 2);
      p += 2;
      if (i < 2) exp_q.push_back('{1'b1, 8'h08, 1'b0, 16'h0, 16'(i), 16'h0, xv[i], CFIP_CLS_VALID});
      else exp_q.push_back('{1'b1, 8'h08, 1'b1, 16'(i/2-1), 16'(i%2), zv[i/2-1], yv[i-2],
        cls(yv[i-2])});
    end
    fix();
    u_cfip_flash_model.mem[a] ^= 8'h41;
    if (a != 254 && a != 512) fix();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int t;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= x;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) break;
    end
    if (t == 50) hang();
    r = axi_rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) break;
    end
    if (t == 50) hang();
    {r, d} = {axi_rsp.rresp, axi_rsp.rdata};
  endtask
  always @(posedge clk) begin
    if (point.valid === 1'b1 && chk_pts) begin
      if (exp_q.size() == 0) chk("extra point", 92'h0, 92'h1);
      else chk("point", exp_q.pop_front(), point);
    end
  end
  initial begin
    axi_req = '0;
    axi_req.wstrb = 4'hf;
    axi_req.bready = 1'b1;
    axi_req.rready = 1'b1;
    {srst, chk_pts, n_fail, cmp_count, seed} = {1'b1, 1'b0, 32'd0, 32'd0, 32'd520};
    {prod, ver, xv[0], xv[1], zv[0], zv[1]} = {$random(seed), $random(seed), $random(seed)};
    ser = 16'({$random(seed)} % 1000);
    bat = 8'({$random(seed)} % 10);
    yr = 8'($random(seed));
    yv = '{16'h7fff, 16'h8000, 16'hfffe, 16'hffff};
    ra = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    ex = '{32'h0, {ver, prod}, {8'h0, bat, ser}, {8'h1f, 8'h0c, 16'(yr) + 16'd1970},
      32'd147000000, 32'd147, 32'h100, 32'h08010101, 32'h6, 32'h2, 32'h2};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wr(8'h31, 32'h1);
    chk("bad write", 92'(CFIP_RESP_DECERR), 92'(r));
    rd(8'h34);
    chk("bad read", 92'({2'b11, 32'h0}), 92'({r, d}));
    for (int c = 0; c < 9; c++) begin
      build(ca[c]);
      chk_pts = (c == 0);
      wr(CFIP_REG_CTRL, 32'h1);
      wr(CFIP_REG_CTRL, 32'h1);
      chk("busy start", 92'h0, 92'(r));
      for (i = 0; i < 3000 && d[1] !== 1'b1; i++) rd(CFIP_REG_STATUS);
      if (i == 3000) hang();
      chk("status", 92'({4'(c), 1'b0, c == 0, 2'b10}), 92'(d[7:0] & 8'hf6));
      if (c == 0) begin
        chk("level found", 92'h1, 92'(d[3]));
        chk("points left", 92'h0, 92'(exp_q.size()));
        for (k = 0; k < 11; k++) begin
          rd(ra[k]);
          chk($sformatf("reg %h", ra[k]), 92'({2'b00, ex[k]}), 92'({r, d}));
        end
        rd(CFIP_REG_CRC);
        chk("running crc", 92'(crc(256, 511)), 92'(d));
      end
      d = 32'h0;
    end
    final_report();
  end
endmodule
